// ===== rtl/tmc_pkg.sv
package tmc_pkg;
    // Channel count and register indices (byte address = 4 * index)
    localparam int          NCH       = 8;
    localparam logic [19:0] CH0_IDX   = 20'hf0190;
    localparam logic [19:0] CH7_IDX   = 20'hf019e;
    localparam logic [19:0] STAT_IDX  = 20'hf01a0;
    localparam logic [19:0] START_IDX = 20'hf01a2;
    localparam logic [19:0] STOP_IDX  = 20'hf01a4;
    // Field positions inside a mode register
    localparam int CKS_LSB = 14;
    localparam int CCS_BIT = 12;
    localparam int B11_BIT = 11;
    localparam int STS_LSB = 8;
    localparam int CIS_LSB = 6;
    localparam int MD_LSB  = 1;
    // Reset value, writable bits, bit 11 and channel groups
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [15:0] WR_MASK   = 16'hd7cf;
    localparam logic [15:0] B11_MASK  = 16'h0800;
    localparam logic [7:0]  MASTER_CH = 8'h54;
    localparam logic [7:0]  SPLIT_CH  = 8'h0a;
    localparam logic [7:0]  CK23_CH   = 8'h0a;
    localparam logic [15:0] ALL_STOP  = 16'h00ff;
    // Trigger source codes
    typedef enum logic [2:0] {
        TMC_STS_SW   = 3'b000,
        TMC_STS_EDGE = 3'b001,
        TMC_STS_BOTH = 3'b010,
        TMC_STS_MINT = 3'b100
    } tmc_sts_t;
    // Input edge codes
    typedef enum logic [1:0] {
        TMC_CIS_FALL = 2'b00,
        TMC_CIS_RISE = 2'b01,
        TMC_CIS_LOW  = 2'b10,
        TMC_CIS_HIGH = 2'b11
    } tmc_cis_t;
endpackage

// ===== rtl/tmc_channel_mode_config.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
// What this block does
// R01: Software writes zero to bits 13, 5 and 4 of each mode register.
// R02: Software stops all channels (00ffh) before changing the CPU clock.
// R03: Bit 11 set on channels 2, 4, 6 makes the channel a master.
// R04: Bit 11 clear means independent or slave of a lower master.
// R05: Only channels 2, 4 and 6 can become master through bit 11.
// R06: Channel 0 is always a master whatever bit 11 holds.
// R07: Software clears bit 11 on channels used independently.
// R08: Channels 1 and 3 with bit 11 clear count as 16-bit timers.
// R09: Channels 1 and 3 with bit 11 set count as 8-bit timers.
// R10: Trigger code 000 starts only by software trigger.
// R11: Code 001 uses the valid pin edge as start and capture.
// R12: Code 010 uses one pin edge to start, the other to capture.
// R13: Code 100 starts a slave from its master interrupt; others prohibited.
// R14: Bit 11 of channels 0, 5 and 7 reads zero, ignores writes.
// R15: Eight mode registers from f0190h to f019eh, reset 0000h.
// R16: Fields: clock 15:14, source 12, trigger 10:8, edge 7:6, mode 3:0.
// R17: Clock code 00/01/10/11 selects clock 0/2/1/3; 2 and 3 on 1,3 only.
// R18: Edge code 00 fall, 01 rise, 10 fall start, 11 rise start.
// R19: Count source 0 uses operation clock, 1 uses input pin edges.
module tmc_channel_mode_config (
    input  wire logic        pclk,          // Bus and timer clock
    input  wire logic        presetn,       // Asynchronous reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB direction
    input  wire logic [21:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // Unmapped access
    input  wire logic [7:0]  timer_input_pin, // Timer input per channel
    input  wire logic [7:0]  master_int,    // Interrupt from each channel
    output logic      [7:0]  running,       // Channel enabled
    output logic      [7:0]  start_trig,    // Start trigger pulse
    output logic      [7:0]  capture_trig,  // Capture trigger pulse
    output logic      [7:0]  pin_count_edge, // Count pulse from pin
    output logic      [7:0]  count_src,     // 1: count pin edges
    output logic      [15:0] op_clock_num,  // Prescaled clock number per channel
    output logic      [7:0]  master_sel,    // Channel is a master
    output logic      [7:0]  half_width,    // Channel counts as 8-bit
    output logic      [7:0]  cfg_error      // Prohibited setting
);
    logic [15:0] mode_ff [8];
    logic [7:0]  run_ff;
    logic [7:0]  pin_ff;
    logic [7:0]  start_ff;
    logic [7:0]  cap_ff;
    logic [7:0]  pcnt_ff;
    logic        pready_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;

    // Nearest lower master of channel n
    function automatic logic [2:0] master_of(input logic [7:0] m, input int n);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < n && m[i])
                r = 3'(i);
        end
        return r;
    endfunction

    // Clock select code to prescaled clock number
    function automatic logic [1:0] clk_num(input logic [1:0] cks);
        return {cks[0], cks[1]}; // R17
    endfunction

    // Address decode
    wire [19:0] idx      = paddr[21:2];
    wire [19:0] ch_off   = idx - tmc_pkg::CH0_IDX;
    wire [2:0]  ch       = ch_off[3:1];
    wire        ch_hit   = idx >= tmc_pkg::CH0_IDX && idx <= tmc_pkg::CH7_IDX && !idx[0]; // R15
    wire        stat_hit = idx == tmc_pkg::STAT_IDX;
    wire        strt_hit = idx == tmc_pkg::START_IDX;
    wire        stop_hit = idx == tmc_pkg::STOP_IDX;
    wire        mapped   = ch_hit | stat_hit | strt_hit | stop_hit;
    wire        acc      = psel & penable & !pready_ff;
    wire        fire     = psel & penable & pready_ff;
    wire        wr_fire  = fire & pwrite & mapped;
    wire        bit11_ok = tmc_pkg::MASTER_CH[ch] | tmc_pkg::SPLIT_CH[ch];
    wire [15:0] wmask    = tmc_pkg::WR_MASK | (bit11_ok ? tmc_pkg::B11_MASK : 16'h0000); // R14
    wire [15:0] wval     = pwdata[15:0] & wmask; // R01
    wire [7:0]  sw_start = (wr_fire & strt_hit) ? pwdata[7:0] : 8'h00;
    wire [7:0]  sw_stop  = (wr_fire & stop_hit) ? pwdata[7:0] : 8'h00; // R02
    wire [31:0] rd_val   = ch_hit ? {16'h0000, mode_ff[ch]} :
                           stat_hit ? {24'h000000, run_ff} : 32'h00000000;

    // Pin edges
    wire [7:0] rise = timer_input_pin & ~pin_ff;
    wire [7:0] fall = ~timer_input_pin & pin_ff;

    logic [7:0] hw_start;
    logic [7:0] hw_cap;
    logic [7:0] valid_e;

    // Per-channel decode of the mode register
    for (genvar n = 0; n < 8; n++)
    begin : g_ch
        wire [1:0] cks  = mode_ff[n][tmc_pkg::CKS_LSB +: 2];
        wire [2:0] sts  = mode_ff[n][tmc_pkg::STS_LSB +: 3];
        wire [1:0] cis  = mode_ff[n][tmc_pkg::CIS_LSB +: 2];
        wire [2:0] md   = mode_ff[n][tmc_pkg::MD_LSB +: 3];
        wire       b11  = mode_ff[n][tmc_pkg::B11_BIT];
        wire       st_e = cis[0] ? rise[n] : fall[n];
        wire       cp_e = cis[0] ? fall[n] : rise[n];
        wire       mi   = master_int[master_of(master_sel, n)];
        wire       md_bad  = md == 3'b001 || md == 3'b101 || md == 3'b111;
        wire       sts_bad = sts != tmc_pkg::TMC_STS_SW && sts != tmc_pkg::TMC_STS_EDGE &&
                             sts != tmc_pkg::TMC_STS_BOTH && sts != tmc_pkg::TMC_STS_MINT; // R13
        // Valid edge: single edge for 00/01, both edges otherwise
        assign valid_e[n] = cis == tmc_pkg::TMC_CIS_FALL ? fall[n] :
                            cis == tmc_pkg::TMC_CIS_RISE ? rise[n] : rise[n] | fall[n]; // R18
        // Hardware start source
        assign hw_start[n] = sts == tmc_pkg::TMC_STS_EDGE ? valid_e[n] : // R11
                             sts == tmc_pkg::TMC_STS_BOTH ? st_e :       // R12
                             sts == tmc_pkg::TMC_STS_MINT ? mi & !master_sel[n] : 1'b0; // R13 R10
        // Hardware capture source
        assign hw_cap[n] = sts == tmc_pkg::TMC_STS_EDGE ? valid_e[n] : // R11
                           sts == tmc_pkg::TMC_STS_BOTH ? cp_e : 1'b0; // R12
        assign master_sel[n] = (n == 0) ? 1'b1 : tmc_pkg::MASTER_CH[n] & b11; // R06 R03 R05 R04
        assign half_width[n] = tmc_pkg::SPLIT_CH[n] & b11; // R09 R08
        assign count_src[n] = mode_ff[n][tmc_pkg::CCS_BIT]; // R19 R16
        assign op_clock_num[2*n +: 2] = clk_num(cks); // R17 R16
        assign cfg_error[n] = sts_bad | md_bad | (cks[0] & !tmc_pkg::CK23_CH[n]); // R17
    end

    // Mode registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 8; i++)
                mode_ff[i] <= tmc_pkg::MODE_RST; // R15
        end
        else if (wr_fire && ch_hit)
        begin
            mode_ff[ch] <= wval;
        end
    end

    // Run flags: start sets, stop clears
    wire [7:0] nxt_run = (run_ff | sw_start) & ~sw_stop; // R02
    wire [7:0] nxt_start = sw_start | (run_ff & hw_start); // R10
    wire [7:0] nxt_cap = run_ff & hw_cap;
    wire [7:0] nxt_pcnt = run_ff & count_src & valid_e; // R19

    // Trigger and edge registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff   <= 8'h00;
            pin_ff   <= 8'h00;
            start_ff <= 8'h00;
            cap_ff   <= 8'h00;
            pcnt_ff  <= 8'h00;
        end
        else
        begin
            run_ff   <= nxt_run;
            pin_ff   <= timer_input_pin;
            start_ff <= nxt_start;
            cap_ff   <= nxt_cap;
            pcnt_ff  <= nxt_pcnt;
        end
    end

    // APB slave: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff  <= acc;
            prdata_ff  <= acc ? rd_val : 32'h00000000;
            pslverr_ff <= acc & !mapped;
        end
    end

    // Outputs
    assign pready         = pready_ff;
    assign prdata         = prdata_ff;
    assign pslverr        = pslverr_ff;
    assign running        = run_ff;
    assign start_trig     = start_ff;
    assign capture_trig   = cap_ff;
    assign pin_count_edge = pcnt_ff;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire wr_ch = wr_fire & ch_hit;

    property p_bit11_ro;
        wr_ch && (ch == 3'd0 || ch == 3'd5 || ch == 3'd7) |=> !mode_ff[$past(ch)][11];
    endproperty
    a_bit11_ro: assert property (p_bit11_ro) else $error("bit 11 stored on fixed channel"); // R14

    property p_reserved;
        wr_ch |=> (mode_ff[$past(ch)] & 16'h2030) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits stored"); // R01

    property p_ch0_master;
        master_sel[0] && (master_sel & 8'hab) == 8'h01;
    endproperty
    a_ch0_master: assert property (p_ch0_master) else $error("wrong master channel"); // R06 R05

    property p_master_set;
        wr_ch && ch == 3'd4 |=> master_sel[4] == $past(pwdata[11]);
    endproperty
    a_master_set: assert property (p_master_set) else $error("master select not taken"); // R03 R04

    property p_split;
        wr_ch && ch == 3'd3 |=> half_width[3] == $past(pwdata[11]) && !master_sel[3];
    endproperty
    a_split: assert property (p_split) else $error("split not taken"); // R08 R09

    property p_sw_only;
        mode_ff[1][10:8] == 3'b000 && sw_start[1] == 1'b0 |=> !start_trig[1] && !capture_trig[1];
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("hardware start in software mode"); // R10

    property p_edge;
        run_ff[2] && mode_ff[2][10:6] == 5'b00101 && rise[2] |=> start_trig[2] && capture_trig[2];
    endproperty
    a_edge: assert property (p_edge) else $error("edge trigger missed"); // R11

    property p_both;
        run_ff[5] && mode_ff[5][10:6] == 5'b01010 && fall[5] |=> start_trig[5] && !capture_trig[5];
    endproperty
    a_both: assert property (p_both) else $error("both-edge start wrong"); // R12

    property p_mint;
        run_ff[1] && mode_ff[1][10:8] == 3'b100 && master_int[0] |=> start_trig[1];
    endproperty
    a_mint: assert property (p_mint) else $error("slave missed master interrupt"); // R13

    property p_stop;
        wr_fire && stop_hit && pwdata[15:0] == tmc_pkg::ALL_STOP |=> running == 8'h00 ##1 !start_trig[0];
    endproperty
    a_stop: assert property (p_stop) else $error("channels not stopped"); // R02

    property p_read;
        acc && !pwrite && ch_hit |=> pready && prdata == {16'h0000, mode_ff[$past(ch)]};
    endproperty
    a_read: assert property (p_read) else $error("mode read wrong"); // R15

    // A prohibited trigger or mode code may still raise the error flag
    property p_clk;
        mode_ff[3][15:14] == 2'b01 |-> op_clock_num[7:6] == 2'd2 &&
            (!cfg_error[3] || mode_ff[3][10:8] inside {3'b011, 3'b101, 3'b110, 3'b111} ||
             mode_ff[3][3:1] inside {3'b001, 3'b101, 3'b111});
    endproperty
    a_clk: assert property (p_clk) else $error("clock map wrong"); // R17

    property p_cnt;
        run_ff[6] && !mode_ff[6][12] |=> !pin_count_edge[6];
    endproperty
    a_cnt: assert property (p_cnt) else $error("pin count with clock source"); // R19

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long"); // R15

    property p_unmapped;
        acc && !mapped |=> pready && pslverr && prdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused"); // R15

    property p_start_run;
        wr_fire && strt_hit |=> (running & $past(pwdata[7:0])) == $past(pwdata[7:0]) &&
            (start_trig & $past(pwdata[7:0])) == $past(pwdata[7:0]);
    endproperty
    a_start_run: assert property (p_start_run) else $error("software start not taken"); // R10

    property p_master_refuse;
        run_ff[2] && master_sel[2] && mode_ff[2][10:8] == 3'b100 && master_int[0] && !sw_start[2]
            |=> !start_trig[2];
    endproperty
    a_master_refuse: assert property (p_master_refuse) else $error("master took master interrupt"); // R13

    property p_master_clear;
        wr_ch && ch == 3'd2 && !pwdata[11] |=> !master_sel[2];
    endproperty
    a_master_clear: assert property (p_master_clear) else $error("master select stuck"); // R04

    property p_pin_count;
        run_ff[5] && mode_ff[5][12] && valid_e[5] |=> pin_count_edge[5];
    endproperty
    a_pin_count: assert property (p_pin_count) else $error("pin count edge missed"); // R19

    property p_cap_both;
        run_ff[5] && mode_ff[5][10:6] == 5'b01010 && rise[5] |=> capture_trig[5] && !start_trig[5];
    endproperty
    a_cap_both: assert property (p_cap_both) else $error("both-edge capture wrong"); // R12 R18

    property p_cfg_clk;
        mode_ff[5][14] |-> cfg_error[5];
    endproperty
    a_cfg_clk: assert property (p_cfg_clk) else $error("clock 2 or 3 allowed on channel 5"); // R17
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [21:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic [7:0]  tpin, mint, running, st, cap, pce, csrc, msel, hw, cerr;
    logic [15:0] ocn, v;
    logic [32:0] expq[$];
    logic [32:0] ex;
    int          failures, n_compared, cyc, n;
    tmc_channel_mode_config tmc_channel_mode_config_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_pin(tpin), .master_int(mint), .running(running), .start_trig(st),
        .capture_trig(cap), .pin_count_edge(pce), .count_src(csrc), .op_clock_num(ocn), .master_sel(msel),
        .half_width(hw), .cfg_error(cerr));
    // Clock generation
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("Compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    function automatic logic [19:0] idx(input int c);
        idx = tmc_pkg::CH0_IDX + 20'(2 * c);
    endfunction
    // Readback: bit 11 kept only on channels 1, 2, 3, 4, 6
    function automatic logic [15:0] rb(input int c, input logic [15:0] d);
        rb = d & (tmc_pkg::WR_MASK | (((8'h5e >> c) & 8'h01) != 8'h00 ? tmc_pkg::B11_MASK : 16'h0000));
    endfunction
    // Prohibited trigger, mode, or clock 2/3 outside channels 1 and 3
    function automatic logic ce(input int c, input logic [15:0] d);
        ce = !(d[10:8] inside {3'b000, 3'b001, 3'b010, 3'b100}) || (d[3:1] inside {3'b001, 3'b101, 3'b111})
             || (d[14] && !(c == 1 || c == 3));
    endfunction
    // APB master; each transfer notes its expected answer
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d, input logic [32:0] e);
        expq.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {a, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Pin edge on channel c, then collect trigger and count pulses for a few cycles
    task automatic pe(input int c, input logic lvl, input logic es, input logic ec, input logic ep);
        logic s, k, p;
        s = 1'b0;
        k = 1'b0;
        p = 1'b0;
        tpin[c] <= lvl;
        repeat (4)
        begin
            @(posedge pclk);
            s = s | st[c];
            k = k | cap[c];
            p = p | pce[c];
        end
        chk("start_trig", s, es);
        chk("capture_trig", k, ec);
        chk("pin_count_edge", p, ep);
    endtask
    // Answer watcher takes the oldest note at each completed transfer
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            ex = expq.pop_front();
            chk("pslverr", pslverr, ex[32]);
            if (!pwrite)
                chk("prdata", prdata, ex[31:0]);
        end
    end
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            complete_run;
        end
    end
    // Main sequence
    initial
    begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 22'h000000;
        pwdata = 32'h00000000;
        tpin = 8'h00;
        mint = 8'h00;
        seed = 32'h3e95;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 8; n++)
            apb(1'b0, idx(n), 32'h0, 33'h0);
        for (int k = 0; k < 24; k++)
        begin
            n = k % 8;
            seed = xs(seed);
            v = seed[15:0] & 16'hdfcf;
            apb(1'b1, idx(n), {16'h0000, v}, 33'h0);
            apb(1'b0, idx(n), 32'h0, {17'h00000, rb(n, v)});
            chk("count_src", csrc[n], v[12]);
            chk("op_clock_num", ocn[2*n+:2], {v[14], v[15]});
            chk("master_sel", msel[n], (n % 2 == 0) && (n == 0 || v[11]));
            chk("half_width", hw[n], (n == 1 || n == 3) && v[11]);
            chk("cfg_error", cerr[n], ce(n, v));
        end
        apb(1'b0, tmc_pkg::STOP_IDX + 20'h2, 32'h0, {1'b1, 32'h0});
        apb(1'b1, idx(2), 32'h0140, 33'h0);
        apb(1'b1, tmc_pkg::START_IDX, 32'h04, 33'h0);
        apb(1'b0, tmc_pkg::STAT_IDX, 32'h0, {1'b0, 32'h04});
        pe(2, 1'b1, 1'b1, 1'b1, 1'b0);
        pe(2, 1'b0, 1'b0, 1'b0, 1'b0);
        apb(1'b1, idx(2), 32'h0240, 33'h0);
        pe(2, 1'b1, 1'b1, 1'b0, 1'b0);
        pe(2, 1'b0, 1'b0, 1'b1, 1'b0);
        apb(1'b1, idx(2), 32'h0040, 33'h0);
        pe(2, 1'b1, 1'b0, 1'b0, 1'b0);
        // Channel 2 master on code 100, channel 1 slave on code 100
        apb(1'b1, idx(2), 32'h0c00, 33'h0);
        apb(1'b1, idx(1), 32'h0400, 33'h0);
        apb(1'b1, tmc_pkg::START_IDX, 32'h02, 33'h0);
        mint[0] <= 1'b1;
        @(posedge pclk);
        mint[0] <= 1'b0;
        @(posedge pclk);
        chk("start_trig", st[1], 1'b1);
        chk("start_trig", st[2], 1'b0);
        // Channel 5 counts pin edges, both edges, falling start
        apb(1'b1, idx(5), 32'h1280, 33'h0);
        apb(1'b1, tmc_pkg::START_IDX, 32'h20, 33'h0);
        pe(5, 1'b1, 1'b0, 1'b1, 1'b1);
        pe(5, 1'b0, 1'b1, 1'b0, 1'b1);
        chk("running", running, 8'h26);
        apb(1'b1, tmc_pkg::STOP_IDX, {16'h0000, tmc_pkg::ALL_STOP}, 33'h0);
        chk("running", running, 8'h00);
        apb(1'b0, tmc_pkg::STAT_IDX, 32'h0, 33'h0);
        complete_run;
    end
endmodule
